// ### rtl/clpd_pkg.sv
// cold load pick-up detector: shared constants, register map and types
// assumes a 25 MHz core clock and a 5 ms processing tick derived from it
//
// What this block does
// R1: comparators release only past 97 % of their setting, hysteresis relative to setting.
// R2: one threshold per comparator, shared by all three phase currents.
// R3: low start true only while all phases below low threshold, default 0.20 In.
// R4: high start true only while all phases above high threshold, default 1.20 In.
// R5: any phase above overcurrent threshold, default 2.00 In, releases active output at once.
// R6: blocking input sampled once at start of each processing tick, used throughout.
// R7: pick-up without blocking sets active output, then operating timers run.
// R8: pick-up with blocking sets blocked output instead, pick-up goes no further.
// R9: blocking during active resets output and runs release handling as at pick-up end.
// R10: blocking raises a time-stamped event with phase currents and fault type.
// R11: blocking source asserts at least 5 ms before operating delay expires.
// R12: active only after low condition lasts start time, 5 ms steps, default 10 s.
// R13: maximum timer runs while above high; release at maximum time, default 30 s.
// R14: active held at least minimum time, default 40 ms; same timer is reclaim window.
// R15: current between low and high ends start-up; release after minimum time.
// R16: zero start time activates immediately once low condition is seen.
// R17: inrush during minimum time starts maximum timer; hold until max or end plus min.
// R18: pre-fault value is 20 ms average of window ending 20 ms before activation.
// R19: events on edges of six flags; selection stores ON, OFF or both edges.
// R20: every event stored with time stamp and current process data.
// R21: status code 0 normal, 1 low, 2 overcurrent, 3 active, 4 blocked.
// R22: measurement source delivers three phase RMS magnitudes on a 5 ms time base.
// R23: timers are counters advanced once per 5 ms tick, compared to settings.
// R24: reset clears timers, outputs and comparators, status code reads 0.

package clpd_pkg;

  // ************************************************************
  // widths and timing
  // ************************************************************
  localparam int CUR_W = 16;   // current in 0.01 x In units
  localparam int TMR_W = 20;   // timer in 5 ms ticks, up to 5242.875 s
  localparam int HIST_DEPTH = 8;
  localparam int NUM_FLAGS = 6;
  localparam int CLK_HZ = 25000000;
  localparam int TICK_MS = 5;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int PCT_FULL = 100;
  localparam int PCT_RESET = 97;
  localparam int PREFAULT_FIRST = 4;   // 20 ms back at 5 ms per sample
  localparam int PREFAULT_SHIFT = 2;   // four samples averaged

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_ILOW = 6'h04;
  localparam logic [5:0] OFS_IHIGH = 6'h08;
  localparam logic [5:0] OFS_IOVER = 6'h0C;
  localparam logic [5:0] OFS_TSET = 6'h10;
  localparam logic [5:0] OFS_TMAX = 6'h14;
  localparam logic [5:0] OFS_TMIN = 6'h18;
  localparam logic [5:0] OFS_STATUS = 6'h1C;
  localparam logic [5:0] OFS_PREFAULT = 6'h20;
  localparam logic [5:0] OFS_EVT = 6'h24;
  localparam logic [5:0] OFS_EVT_TIME = 6'h28;
  localparam logic [5:0] OFS_EVT_I12 = 6'h2C;
  localparam logic [5:0] OFS_EVT_I3 = 6'h30;

  // field positions
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_OFF_BIT = 1;
  localparam int STAT_ACTIVE_BIT = 4;
  localparam int STAT_BLOCKED_BIT = 5;
  localparam int STAT_FLAGS_LSB = 8;
  localparam int EVT_OFF_LSB = 8;
  localparam int EVT_PEND_BIT = 31;
  localparam int EVT_CODE_LSB = 16;

  // reset values
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam logic [CUR_W-1:0] ILOW_RESET = 16'h0014;    // 0.20 x In
  localparam logic [CUR_W-1:0] IHIGH_RESET = 16'h0078;   // 1.20 x In
  localparam logic [CUR_W-1:0] IOVER_RESET = 16'h00C8;   // 2.00 x In
  localparam logic [TMR_W-1:0] TSET_RESET = 20'h0_07D0;  // 10.000 s
  localparam logic [TMR_W-1:0] TMAX_RESET = 20'h0_1770;  // 30.000 s
  localparam logic [TMR_W-1:0] TMIN_RESET = 20'h0_0008;  // 0.040 s

  // ************************************************************
  // status codes, flag order, states
  // ************************************************************
  localparam logic [2:0] CODE_NORMAL = 3'h0;
  localparam logic [2:0] CODE_LOW = 3'h1;
  localparam logic [2:0] CODE_OVER = 3'h2;
  localparam logic [2:0] CODE_ACTIVE = 3'h3;
  localparam logic [2:0] CODE_BLOCKED = 3'h4;

  localparam int FL_LOW = 0;
  localparam int FL_HIGH = 1;
  localparam int FL_NORMAL = 2;
  localparam int FL_OVER = 3;
  localparam int FL_ACT = 4;
  localparam int FL_BLK = 5;

  typedef enum logic [1:0] {ST_IDLE, ST_QUALIFY, ST_ACTIVE, ST_BLOCKED} clpd_state_t;

endpackage

// ### rtl/clpd_cold_load_pickup.sv
// cold load pick-up detector with its Avalon-MM register slave
// assumes phase magnitudes and the block input are synchronous to core_clk
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module clpd_cold_load_pickup #(
  parameter int TICK_CYCLES = clpd_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [15:0] phase1_rms_current,
  input wire logic [15:0] phase2_rms_current,
  input wire logic [15:0] phase3_rms_current,
  input wire logic blockIn,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic coldLoadActive,
  output logic blockedOut,
  output logic [2:0] functionStatusCode,
  output logic eventValid
);

  // ************************************************************
  // processing tick
  // ************************************************************
  logic [19:0] tickCnt_reg;
  logic tick_reg;
  logic evalStrobe_reg;
  logic [31:0] timeStamp_reg;
  wire tickWrap = (tickCnt_reg == 20'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      tickCnt_reg <= 20'h0_0000;
      tick_reg <= 1'b0;
      evalStrobe_reg <= 1'b0;
      timeStamp_reg <= 32'h0000_0000;
    end
    else
    begin
      tickCnt_reg <= tickWrap ? 20'h0_0000 : tickCnt_reg + 20'h0_0001;
      tick_reg <= tickWrap;
      evalStrobe_reg <= tick_reg;
      if (tickWrap)
        timeStamp_reg <= timeStamp_reg + 32'h0000_0001;
    end
  end

  // ************************************************************
  // sampling at start of each tick
  // ************************************************************
  logic [15:0] samp_reg [3];
  logic blockSample_reg;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      samp_reg[0] <= 16'h0000;
      samp_reg[1] <= 16'h0000;
      samp_reg[2] <= 16'h0000;
      blockSample_reg <= 1'b0;
    end
    else if (tick_reg)
    begin
      samp_reg[0] <= phase1_rms_current;
      samp_reg[1] <= phase2_rms_current;
      samp_reg[2] <= phase3_rms_current;
      blockSample_reg <= blockIn; // see R6
    end
  end

  // ************************************************************
  // settings registers
  // ************************************************************
  logic [1:0] ctrl_reg;
  logic [15:0] iLow_reg;
  logic [15:0] iHigh_reg;
  logic [15:0] iOver_reg;
  logic [19:0] tSet_reg;
  logic [19:0] tMax_reg;
  logic [19:0] tMin_reg;

  // ************************************************************
  // comparators with 97 % reset ratio, one per phase
  // ************************************************************
  logic [2:0] lowPh_reg;
  logic [2:0] highPh_reg;
  logic [2:0] overPh_reg;
  logic [2:0] lowPhNext;
  logic [2:0] highPhNext;
  logic [2:0] overPhNext;

  genvar p;
  generate
    for (p = 0; p < 3; p++)
    begin : gPhase
      wire [23:0] iFull = 24'(samp_reg[p]) * 24'(clpd_pkg::PCT_FULL);
      wire [23:0] iRst = 24'(samp_reg[p]) * 24'(clpd_pkg::PCT_RESET);
      wire [23:0] lowFull = 24'(iLow_reg) * 24'(clpd_pkg::PCT_FULL);
      wire [23:0] highRst = 24'(iHigh_reg) * 24'(clpd_pkg::PCT_RESET);
      wire [23:0] overRst = 24'(iOver_reg) * 24'(clpd_pkg::PCT_RESET);
      // one shared setting per comparator for all phases, see R2
      assign lowPhNext[p] = lowPh_reg[p] ? (iRst < lowFull) : (samp_reg[p] < iLow_reg); // see R1
      assign highPhNext[p] = highPh_reg[p] ? (iFull >= highRst) : (samp_reg[p] > iHigh_reg); // see R1
      assign overPhNext[p] = overPh_reg[p] ? (iFull >= overRst) : (samp_reg[p] > iOver_reg); // see R1
    end
  endgenerate

  wire lowCond = &lowPhNext;   // see R3
  wire highCond = &highPhNext; // see R4
  wire overCond = |overPhNext; // see R5
  wire betweenCond = !lowCond && !highCond;

  // ************************************************************
  // pre-fault history of the highest phase
  // ************************************************************
  wire [15:0] max12 = (samp_reg[0] > samp_reg[1]) ? samp_reg[0] : samp_reg[1];
  wire [15:0] maxPhase = (max12 > samp_reg[2]) ? max12 : samp_reg[2];
  logic [15:0] hist_reg [clpd_pkg::HIST_DEPTH];

  generate
    for (p = 0; p < clpd_pkg::HIST_DEPTH; p++)
    begin : gHist
      always_ff @(posedge core_clk)
      begin
        if (!reset_n)
          hist_reg[p] <= 16'h0000;
        else if (evalStrobe_reg)
          hist_reg[p] <= (p == 0) ? maxPhase : hist_reg[(p == 0) ? 0 : p - 1];
      end
    end
  endgenerate

  // window from -20 ms back to -35 ms, averaged over 20 ms; hist_reg[0] is already one tick old, see R18
  wire [17:0] preSum = 18'(hist_reg[clpd_pkg::PREFAULT_FIRST - 1]) + 18'(hist_reg[clpd_pkg::PREFAULT_FIRST])
                     + 18'(hist_reg[clpd_pkg::PREFAULT_FIRST + 1]) + 18'(hist_reg[clpd_pkg::PREFAULT_FIRST + 2]);
  wire [15:0] preAvg = 16'(preSum >> clpd_pkg::PREFAULT_SHIFT);

  // ************************************************************
  // operating state machine, evaluated once per tick
  // ************************************************************
  clpd_pkg::clpd_state_t state_reg;
  logic [19:0] qualCnt_reg;
  logic [19:0] minCnt_reg;
  logic [19:0] maxCnt_reg;
  logic inrush_reg;
  logic startupOver_reg;
  logic [15:0] preFault_reg;

  wire [19:0] qualInc = qualCnt_reg + 20'h0_0001;
  wire [19:0] minInc = (minCnt_reg >= tMin_reg) ? minCnt_reg : minCnt_reg + 20'h0_0001;
  wire [19:0] maxInc = maxCnt_reg + 20'h0_0001;
  wire minDone = (minInc >= tMin_reg);                          // see R14
  wire maxDone = highCond && (maxInc >= tMax_reg);               // see R13
  wire inrushNext = inrush_reg || highCond;
  wire overNext = startupOver_reg || (inrush_reg && betweenCond); // see R15
  // no inrush inside the minimum time acts as reclaim; inrush keeps it held, see R17
  wire normalRelease = minDone && !highCond && (overNext || !inrushNext); // see R14
  wire pickup = (state_reg == clpd_pkg::ST_IDLE && lowCond && tSet_reg == 20'h0_0000)
              || (state_reg == clpd_pkg::ST_QUALIFY && lowCond && qualInc >= tSet_reg); // see R12

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_reg <= clpd_pkg::ST_IDLE; // see R24
      qualCnt_reg <= 20'h0_0000;
      minCnt_reg <= 20'h0_0000;
      maxCnt_reg <= 20'h0_0000;
      inrush_reg <= 1'b0;
      startupOver_reg <= 1'b0;
      coldLoadActive <= 1'b0;
      blockedOut <= 1'b0;
      preFault_reg <= 16'h0000;
      lowPh_reg <= 3'h0;
      highPh_reg <= 3'h0;
      overPh_reg <= 3'h0;
    end
    else if (evalStrobe_reg)
    begin
      lowPh_reg <= lowPhNext;
      highPh_reg <= highPhNext;
      overPh_reg <= overPhNext;
      if (pickup)
      begin
        qualCnt_reg <= 20'h0_0000;
        minCnt_reg <= 20'h0_0000;
        maxCnt_reg <= 20'h0_0000;
        inrush_reg <= 1'b0;
        startupOver_reg <= 1'b0;
        if (blockSample_reg)
        begin
          state_reg <= clpd_pkg::ST_BLOCKED; // see R8
          blockedOut <= 1'b1;
        end
        else
        begin
          state_reg <= clpd_pkg::ST_ACTIVE; // see R7, R16
          coldLoadActive <= 1'b1;
          preFault_reg <= preAvg; // see R18
        end
      end
      else
      begin
        case (state_reg)
          clpd_pkg::ST_IDLE:
          begin
            if (lowCond)
              state_reg <= clpd_pkg::ST_QUALIFY;
            qualCnt_reg <= 20'h0_0000;
          end
          clpd_pkg::ST_QUALIFY:
          begin
            if (lowCond)
              qualCnt_reg <= qualInc; // see R23
            else
              state_reg <= clpd_pkg::ST_IDLE;
          end
          clpd_pkg::ST_ACTIVE:
          begin
            minCnt_reg <= minInc; // see R23
            inrush_reg <= inrushNext;
            startupOver_reg <= overNext;
            if (highCond)
              maxCnt_reg <= maxInc; // see R13, R17
            if (overCond)
            begin
              state_reg <= clpd_pkg::ST_IDLE; // see R5
              coldLoadActive <= 1'b0;
            end
            else if (blockSample_reg)
            begin
              // output drops now; timers kept as on normal release, cleared at next pick-up, see R9
              state_reg <= clpd_pkg::ST_BLOCKED;
              coldLoadActive <= 1'b0;
              blockedOut <= 1'b1;
            end
            else if (maxDone || normalRelease)
            begin
              state_reg <= clpd_pkg::ST_IDLE; // see R13, R15
              coldLoadActive <= 1'b0;
            end
          end
          clpd_pkg::ST_BLOCKED:
          begin
            if (!blockSample_reg)
            begin
              state_reg <= clpd_pkg::ST_IDLE;
              blockedOut <= 1'b0;
            end
          end
          default:
          begin
            state_reg <= clpd_pkg::ST_IDLE;
            coldLoadActive <= 1'b0;
            blockedOut <= 1'b0;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // flags, status code and event capture
  // ************************************************************
  wire lowFlag = &lowPh_reg;
  wire highFlag = &highPh_reg;
  wire overFlag = |overPh_reg;
  wire [5:0] flagVec = {blockedOut, coldLoadActive, overFlag, !lowFlag && !highFlag && !overFlag, highFlag, lowFlag};
  logic [5:0] flagPrev_reg;
  wire [5:0] onEdges = flagVec & ~flagPrev_reg & {6{ctrl_reg[clpd_pkg::CTRL_ON_BIT]}};  // see R19
  wire [5:0] offEdges = ~flagVec & flagPrev_reg & {6{ctrl_reg[clpd_pkg::CTRL_OFF_BIT]}}; // see R19
  wire newEvent = |{onEdges, offEdges};
  wire [2:0] codeNext = blockedOut ? clpd_pkg::CODE_BLOCKED
                      : coldLoadActive ? clpd_pkg::CODE_ACTIVE
                      : overFlag ? clpd_pkg::CODE_OVER
                      : (lowFlag || state_reg == clpd_pkg::ST_QUALIFY) ? clpd_pkg::CODE_LOW
                      : clpd_pkg::CODE_NORMAL; // see R21

  logic [5:0] evOn_reg;
  logic [5:0] evOff_reg;
  logic [31:0] evTime_reg;
  logic [15:0] evCur_reg [3];
  logic [2:0] evCode_reg;
  logic evPending_reg;

  // bus decode, see further below
  wire busWrite;
  wire pendClear;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      flagPrev_reg <= 6'h00;
      functionStatusCode <= clpd_pkg::CODE_NORMAL; // see R24
      eventValid <= 1'b0;
      evOn_reg <= 6'h00;
      evOff_reg <= 6'h00;
      evTime_reg <= 32'h0000_0000;
      evCur_reg[0] <= 16'h0000;
      evCur_reg[1] <= 16'h0000;
      evCur_reg[2] <= 16'h0000;
      evCode_reg <= clpd_pkg::CODE_NORMAL;
      evPending_reg <= 1'b0;
    end
    else
    begin
      flagPrev_reg <= flagVec;
      functionStatusCode <= codeNext;
      eventValid <= newEvent;
      // set wins over a software clear in the same cycle
      evPending_reg <= newEvent || (evPending_reg && !pendClear);
      if (newEvent)
      begin
        evOn_reg <= onEdges;
        evOff_reg <= offEdges;
        evTime_reg <= timeStamp_reg; // see R20
        evCur_reg[0] <= samp_reg[0]; // see R10, R20
        evCur_reg[1] <= samp_reg[1];
        evCur_reg[2] <= samp_reg[2];
        evCode_reg <= codeNext; // see R10
      end
    end
  end

  // ************************************************************
  // Avalon-MM slave: one wait state, answer on the second edge
  // ************************************************************
  wire request = read || write;
  assign busWrite = write && !waitrequest;
  wire hit = (address == clpd_pkg::OFS_EVT);
  assign pendClear = busWrite && hit && byteenable[3] && writedata[clpd_pkg::EVT_PEND_BIT];

  function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal, input logic [31:0] newVal,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++)
      if (be[b])
        res[b*8 +: 8] = newVal[b*8 +: 8];
    return res;
  endfunction

  wire [31:0] statusWord = {18'h0_0000, flagVec, 2'h0, blockedOut, coldLoadActive, 1'b0, functionStatusCode};
  wire [31:0] evtWord = {evPending_reg, 15'h0000, 2'h0, evOff_reg, 2'h0, evOn_reg};
  logic [31:0] readMux;

  always_comb
  begin
    case (address)
      clpd_pkg::OFS_CTRL: readMux = {30'h0000_0000, ctrl_reg};
      clpd_pkg::OFS_ILOW: readMux = {16'h0000, iLow_reg};
      clpd_pkg::OFS_IHIGH: readMux = {16'h0000, iHigh_reg};
      clpd_pkg::OFS_IOVER: readMux = {16'h0000, iOver_reg};
      clpd_pkg::OFS_TSET: readMux = {12'h000, tSet_reg};
      clpd_pkg::OFS_TMAX: readMux = {12'h000, tMax_reg};
      clpd_pkg::OFS_TMIN: readMux = {12'h000, tMin_reg};
      clpd_pkg::OFS_STATUS: readMux = statusWord;
      clpd_pkg::OFS_PREFAULT: readMux = {16'h0000, preFault_reg};
      clpd_pkg::OFS_EVT: readMux = evtWord;
      clpd_pkg::OFS_EVT_TIME: readMux = evTime_reg;
      clpd_pkg::OFS_EVT_I12: readMux = {evCur_reg[1], evCur_reg[0]};
      clpd_pkg::OFS_EVT_I3: readMux = {13'h0000, evCode_reg, evCur_reg[2]};
      default: readMux = 32'h0000_0000;
    endcase
  end

  wire [31:0] wrMerged = mergeBytes(readMux, writedata, byteenable);

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
      ctrl_reg <= clpd_pkg::CTRL_RESET;
      iLow_reg <= clpd_pkg::ILOW_RESET;
      iHigh_reg <= clpd_pkg::IHIGH_RESET;
      iOver_reg <= clpd_pkg::IOVER_RESET;
      tSet_reg <= clpd_pkg::TSET_RESET;
      tMax_reg <= clpd_pkg::TMAX_RESET;
      tMin_reg <= clpd_pkg::TMIN_RESET;
    end
    else
    begin
      // drop waitrequest for exactly one edge per request
      waitrequest <= !(request && waitrequest);
      if (read && waitrequest)
        readdata <= readMux;
      if (busWrite)
      begin
        case (address)
          clpd_pkg::OFS_CTRL: ctrl_reg <= wrMerged[1:0];
          clpd_pkg::OFS_ILOW: iLow_reg <= wrMerged[15:0];
          clpd_pkg::OFS_IHIGH: iHigh_reg <= wrMerged[15:0];
          clpd_pkg::OFS_IOVER: iOver_reg <= wrMerged[15:0];
          clpd_pkg::OFS_TSET: tSet_reg <= wrMerged[19:0];
          clpd_pkg::OFS_TMAX: tMax_reg <= wrMerged[19:0];
          clpd_pkg::OFS_TMIN: tMin_reg <= wrMerged[19:0];
          default: ;
        endcase
      end
    end
  end

endmodule // clpd_cold_load_pickup

// ### bench/clpd_checker_assertions.sv
// checker: port-level properties of the cold load pick-up detector
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module clpd_checker #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic coldLoadActive,
  input wire logic blockedOut,
  input wire logic [2:0] functionStatusCode,
  input wire logic eventValid
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_act_rise;
    $rose(coldLoadActive);
  endsequence
  sequence s_evt_seen;
    ##[1:3] eventValid;
  endsequence
  chk_out_exclusive: assert property (!(coldLoadActive && blockedOut))
    else $error("active and blocked high together");
  chk_reset_clear: assert property ($rose(reset_n) |-> !coldLoadActive && !blockedOut && !eventValid
    && functionStatusCode == clpd_pkg::CODE_NORMAL)
    else $error("outputs not cleared by reset");
  chk_code_active: assert property (s_act_rise |=> functionStatusCode == clpd_pkg::CODE_ACTIVE)
    else $error("status code not active");
  chk_code_blocked: assert property ($rose(blockedOut) |=> functionStatusCode == clpd_pkg::CODE_BLOCKED)
    else $error("status code not blocked");
  chk_act_event: assert property (s_act_rise |-> s_evt_seen)
    else $error("no event after activation");
  chk_event_pulse: assert property (eventValid |=> !eventValid)
    else $error("event strobe longer than one cycle");
  chk_act_steady: assert property ($changed(coldLoadActive) |=> $stable(coldLoadActive)[*3])
    else $error("active output changed between ticks");
  chk_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered");
  chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  chk_wait_idle: assert property (!read && !write && $past(!read && !write) |-> waitrequest)
    else $error("waitrequest low while idle");
endmodule // clpd_checker
bind clpd_cold_load_pickup clpd_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.core_clk(core_clk),
  .reset_n(reset_n), .read(read), .write(write), .waitrequest(waitrequest), .coldLoadActive(coldLoadActive),
  .blockedOut(blockedOut), .functionStatusCode(functionStatusCode), .eventValid(eventValid));

// ### bench/clpd_meas_source.sv
// model of the measurement front end: three phase magnitudes and the block line
// assumes the bench calls apply from its own clocked sequence
`timescale 1ns/1ps
module clpd_meas_source (
  input wire logic core_clk,
  output logic [15:0] phaseA,
  output logic [15:0] phaseB,
  output logic [15:0] phaseC,
  output logic blockOut
);
  initial
  begin
    {phaseA, phaseB, phaseC, blockOut} = 49'h0;
  end
  // levels held for whole ticks; block raised ticks before any timer ends
  task automatic apply(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c, input logic blk);
    @(posedge core_clk);
    phaseA <= a;
    phaseB <= b;
    phaseC <= c;
    blockOut <= blk;
  endtask
endmodule // clpd_meas_source

// ### bench/clpd_cold_load_pickup_tb.sv
// testbench: register access and pick-up sequences for the detector
// assumes a 20-cycle tick so that timer settings stay short
`timescale 1ns/1ps
module clpd_cold_load_pickup_tb;
  localparam int TK = 20;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic [31:0] rd;
  logic waitrequest, coldLoadActive, blockedOut, eventValid, blk;
  logic [2:0] code;
  logic [15:0] p1, p2, p3;
  logic [5:0] ofs [7] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18};
  logic [31:0] dflt [7] = '{32'h0000_0003, 32'h0000_0014, 32'h0000_0078, 32'h0000_00C8,
    32'h0000_07D0, 32'h0000_1770, 32'h0000_0008};
  int badCount = 0;
  int nCompared = 0;
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  clpd_cold_load_pickup #(.TICK_CYCLES(TK)) i_dut (.core_clk(core_clk), .reset_n(reset_n),
    .phase1_rms_current(p1), .phase2_rms_current(p2), .phase3_rms_current(p3), .blockIn(blk),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
    .readdata(readdata), .waitrequest(waitrequest), .coldLoadActive(coldLoadActive),
    .blockedOut(blockedOut), .functionStatusCode(code), .eventValid(eventValid));
  clpd_meas_source i_src (.core_clk(core_clk), .phaseA(p1), .phaseB(p2), .phaseC(p3), .blockOut(blk));
  // ********
  // tasks
  // ********
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    write <= wr;
    read <= ~wr;
    address <= a;
    writedata <= d;
    @(posedge core_clk);
    while (waitrequest !== 1'b0) @(posedge core_clk);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    check($sformatf("reg %h", a), rd, e);
  endtask
  // a few cycles past the tick edge so the outputs have settled
  task automatic ticks(input int n);
    repeat (n * TK + 4) @(posedge core_clk);
  endtask
  task automatic outs(input logic act, input logic bo, input logic [2:0] c);
    check("active", 32'(coldLoadActive), 32'(act));
    check("blocked", 32'(blockedOut), 32'(bo));
    check("code", 32'(code), 32'(c));
  endtask
  task automatic endSim;
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge core_clk);
    badCount++;
    endSim();
  end
  // ********
  // sequence
  // ********
  initial
  begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    outs(1'b0, 1'b0, clpd_pkg::CODE_NORMAL);
    for (int i = 0; i < 7; i++) rchk(ofs[i], dflt[i]);
    rchk(6'h3C, 32'h0000_0000);
    i_src.apply(16'h0000, 16'h0000, 16'h001E, 1'b0);
    bus(1'b1, clpd_pkg::OFS_TSET, 32'h0000_0003);
    bus(1'b1, clpd_pkg::OFS_TMAX, 32'h0000_0004);
    bus(1'b1, clpd_pkg::OFS_TMIN, 32'h0000_0002);
    rchk(clpd_pkg::OFS_TSET, 32'h0000_0003);
    ticks(5);
    outs(1'b0, 1'b0, clpd_pkg::CODE_NORMAL);
    i_src.apply(16'h0000, 16'h0000, 16'h0000, 1'b0);
    ticks(2);
    outs(1'b0, 1'b0, clpd_pkg::CODE_LOW);
    ticks(3);
    outs(1'b1, 1'b0, clpd_pkg::CODE_ACTIVE);
    bus(1'b0, clpd_pkg::OFS_EVT, 32'h0000_0000);
    check("event", {rd[31], 26'h0, rd[clpd_pkg::FL_ACT], 4'h0}, 32'h8000_0010);
    rchk(clpd_pkg::OFS_EVT_I12, 32'h0000_0000);
    i_src.apply(16'h0096, 16'h0096, 16'h0096, 1'b0);
    ticks(2);
    outs(1'b1, 1'b0, clpd_pkg::CODE_ACTIVE);
    ticks(5);
    check("max release", 32'(coldLoadActive), 32'h0000_0000);
    i_src.apply(16'h0000, 16'h0000, 16'h0000, 1'b0);
    ticks(5);
    i_src.apply(16'h0096, 16'h0096, 16'h0096, 1'b0);
    ticks(1);
    i_src.apply(16'h0096, 16'h0096, 16'h0032, 1'b0);
    ticks(2);
    check("startup over", 32'(coldLoadActive), 32'h0000_0000);
    i_src.apply(16'h0000, 16'h0000, 16'h0000, 1'b0);
    ticks(5);
    i_src.apply(16'h00FA, 16'h00FA, 16'h00FA, 1'b0);
    ticks(1);
    outs(1'b0, 1'b0, clpd_pkg::CODE_OVER);
    i_src.apply(16'h0000, 16'h0000, 16'h0000, 1'b1);
    ticks(5);
    outs(1'b0, 1'b1, clpd_pkg::CODE_BLOCKED);
    bus(1'b0, clpd_pkg::OFS_EVT, 32'h0000_0000);
    check("block event", 32'(rd[clpd_pkg::FL_BLK]), 32'h0000_0001);
    rchk(clpd_pkg::OFS_EVT_I3, 32'h0004_0000);
    i_src.apply(16'h0032, 16'h0032, 16'h0032, 1'b0);
    ticks(2);
    i_src.apply(16'h0000, 16'h0000, 16'h0000, 1'b0);
    ticks(4);
    outs(1'b1, 1'b0, clpd_pkg::CODE_ACTIVE);
    i_src.apply(16'h0000, 16'h0000, 16'h0000, 1'b1);
    ticks(1);
    check("block drops active", {30'h0, coldLoadActive, blockedOut}, 32'h0000_0001);
    i_src.apply(16'h0000, 16'h0000, 16'h0000, 1'b0);
    bus(1'b1, clpd_pkg::OFS_TSET, 32'h0000_0000);
    ticks(1);
    check("zero start", 32'(coldLoadActive), 32'h0000_0001);
    rchk(clpd_pkg::OFS_PREFAULT, 32'h0000_000C);
    endSim();
  end
endmodule // clpd_cold_load_pickup_tb
